// File: verilog/ncs_top.sv
`default_nettype none

module ncs_top
  import ncs_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // pins and device events
  input wire logic load_sel,
  input wire logic status_sel,
  input wire logic soft_reset_req,
  output logic status_pin,
  output logic i2c_nack,
  // host register port
  input wire logic reg_req,
  input wire logic reg_wr,
  input wire logic [REG_AW-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic reg_ack,
  output logic [7:0] reg_rdata,
  // device register bank
  output logic [REG_AW-1:0] cfg_addr,
  output logic cfg_rd_en,
  input wire logic [7:0] cfg_rd_data,
  output logic cfg_wr_en,
  output logic [7:0] cfg_wr_data,
  output logic cfg_update,
  output logic cfg_load_defaults
);

  // ***************************************************************
  // helpers
  // ***************************************************************
  function automatic logic is_seg(input logic [REG_AW-1:0] a);
    return (a >= ADDR_SEG_BASE) && (a < ADDR_SEG_BASE + 16'(SEG_BYTES));
  endfunction : is_seg

  function automatic logic [SEG_AW-1:0] seg_off(input logic [REG_AW-1:0] a);
    logic [REG_AW-1:0] d;
    d = a - ADDR_SEG_BASE;
    return d[SEG_AW-1:0];
  endfunction : seg_off

  // ***************************************************************
  // state
  // ***************************************************************
  ncs_state_t state_reg;
  logic busy_reg;
  logic error_reg;
  logic wr_en_reg;
  logic save_req_reg;
  logic save_mode_reg;
  logic resume_reg;
  logic started_reg;
  logic [NVM_AW:0] nvm_ptr_reg;
  logic [SEG_AW:0] seg_idx_reg;
  logic [1:0] phase_reg;
  logic [6:0] count_reg;
  logic [REG_AW-1:0] rptr_reg;
  logic rd_valid_reg;
  logic rd_blk_reg;
  logic [REG_AW-1:0] rd_addr_reg;

  ncs_mem_if #(.AW(NVM_AW), .DW(8)) nvm_bus ();
  ncs_mem_if #(.AW(SEG_AW), .DW(8)) seg_bus ();

  ncs_nvm_store #(.DEPTH(NVM_BYTES)) u_store (
    .sys_clk(sys_clk),
    .bus(nvm_bus)
  );

  ncs_seg_buffer #(.DEPTH(SEG_BYTES)) u_seg (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .bus(seg_bus)
  );

  // ***************************************************************
  // host decode and starts
  // ***************************************************************
  logic wr_hit;
  logic commit_wr;
  logic power_up;
  logic reset_event;
  logic start_save;
  logic save_refused;
  logic start_restore;

  assign wr_hit = reg_req && reg_wr && !busy_reg;
  assign commit_wr = wr_hit && (reg_addr == ADDR_COMMIT) && reg_wdata[BIT_COMMIT];
  assign power_up = !started_reg;
  assign reset_event = power_up || soft_reset_req;
  assign start_save = commit_wr && save_req_reg && wr_en_reg;
  assign save_refused = commit_wr && save_req_reg && !wr_en_reg;
  // a restore may only begin from idle; requests during a transfer are dropped
  assign start_restore = !busy_reg && !start_save &&
                         ((reset_event && load_sel) ||
                          (wr_hit && (reg_addr == ADDR_WE_RELOAD) &&
                           reg_wdata[BIT_RELOAD] && !load_sel));

  // ***************************************************************
  // walker decode
  // ***************************************************************
  logic [7:0] tok;
  logic dec;
  logic op_slot;
  logic is_end;
  logic is_pseudo;
  logic is_commit;
  logic bad_op;
  logic ovf;
  logic seg_ovf;
  logic fail;
  logic fin;

  assign tok = save_mode_reg ? seg_bus.rdata : nvm_bus.rdata;
  assign dec = (state_reg == ST_DECODE);
  assign op_slot = dec && (phase_reg == PH_COUNT);
  assign is_end = op_slot && ((tok == OP_END) ||
                              (!save_mode_reg && (tok == OP_PSEUDO_END)));
  assign is_pseudo = op_slot && save_mode_reg && (tok == OP_PSEUDO_END);
  assign is_commit = op_slot && (tok == OP_COMMIT);
  // an unknown code in the count slot is treated as a broken segment
  assign bad_op = op_slot && tok[OP_FLAG_BIT] && !is_end && !is_pseudo && !is_commit;
  assign ovf = nvm_ptr_reg[NVM_AW] &&
               (save_mode_reg ? ((dec && !is_pseudo) || (state_reg == ST_DATA_WAIT))
                              : ((state_reg == ST_FETCH) || (state_reg == ST_DATA)));
  assign seg_ovf = save_mode_reg && (state_reg == ST_FETCH) &&
                   (seg_idx_reg >= (SEG_AW + 1)'(SEG_BYTES));
  assign fail = ovf || bad_op || seg_ovf;
  assign fin = fail || is_end || is_pseudo;

  // ***************************************************************
  // memory ports
  // ***************************************************************
  // the store is only ever driven by the walker, never by the host
  assign nvm_bus.addr = nvm_ptr_reg[NVM_AW-1:0];
  assign nvm_bus.we = save_mode_reg && !fail &&
                      ((dec && !is_pseudo) || (state_reg == ST_DATA_WAIT));
  assign nvm_bus.wdata = dec ? seg_bus.rdata : cfg_rd_data;

  assign seg_bus.addr = busy_reg ? seg_idx_reg[SEG_AW-1:0] : seg_off(reg_addr);
  assign seg_bus.we = wr_hit && is_seg(reg_addr);
  assign seg_bus.wdata = reg_wdata;

  // ***************************************************************
  // walker
  // ***************************************************************
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      state_reg <= ST_IDLE;
      save_mode_reg <= 1'b0;
      nvm_ptr_reg <= '0;
      seg_idx_reg <= '0;
      phase_reg <= PH_COUNT;
      count_reg <= '0;
      rptr_reg <= '0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          phase_reg <= PH_COUNT;
          seg_idx_reg <= '0;
          if (start_save) begin
            save_mode_reg <= 1'b1;
            if (!resume_reg) begin
              nvm_ptr_reg <= '0;
            end
            state_reg <= ST_FETCH;
          end else if (start_restore) begin
            save_mode_reg <= 1'b0;
            nvm_ptr_reg <= '0;
            state_reg <= ST_FETCH;
          end
        end
        ST_FETCH: begin
          state_reg <= fail ? ST_IDLE : ST_DECODE;
        end
        ST_DECODE: begin
          if (fin) begin
            state_reg <= ST_IDLE;
          end else begin
            nvm_ptr_reg <= nvm_ptr_reg + 1'b1;
            seg_idx_reg <= seg_idx_reg + 1'b1;
            state_reg <= ST_FETCH;
            case (phase_reg)
              PH_COUNT: begin
                if (!tok[OP_FLAG_BIT]) begin
                  count_reg <= tok[6:0];
                  phase_reg <= PH_ADDR_LO;
                end
              end
              PH_ADDR_LO: begin
                rptr_reg[7:0] <= tok;
                phase_reg <= PH_ADDR_HI;
              end
              default: begin
                rptr_reg[15:8] <= tok;
                phase_reg <= PH_COUNT;
                state_reg <= ST_DATA;
              end
            endcase
          end
        end
        ST_DATA: begin
          state_reg <= fail ? ST_IDLE : ST_DATA_WAIT;
        end
        ST_DATA_WAIT: begin
          if (fail) begin
            state_reg <= ST_IDLE;
          end else begin
            nvm_ptr_reg <= nvm_ptr_reg + 1'b1;
            rptr_reg <= rptr_reg + 1'b1;
            count_reg <= count_reg - 1'b1;
            state_reg <= (count_reg == '0) ? ST_FETCH : ST_DATA;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // ***************************************************************
  // flags
  // ***************************************************************
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      started_reg <= 1'b0;
    end else begin
      started_reg <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      busy_reg <= 1'b0;
    end else if (start_save || start_restore) begin
      busy_reg <= 1'b1;
    end else if (fin) begin
      busy_reg <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      error_reg <= 1'b0;
    end else if (start_save || start_restore) begin
      error_reg <= 1'b0;
    end else if (fail || save_refused) begin
      error_reg <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      wr_en_reg <= 1'b0;
    end else if (wr_hit && (reg_addr == ADDR_WE_RELOAD)) begin
      wr_en_reg <= reg_wdata[BIT_WR_EN];
    end
  end

  // host writes are blocked while busy, so set and clear never meet
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      save_req_reg <= 1'b0;
    end else if (busy_reg && save_mode_reg && fin) begin
      save_req_reg <= 1'b0;
    end else if (save_refused) begin
      save_req_reg <= 1'b0;
    end else if (wr_hit && (reg_addr == ADDR_SAVE_REQ)) begin
      save_req_reg <= reg_wdata[BIT_SAVE_REQ];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      resume_reg <= 1'b0;
    end else if (is_pseudo && !fail) begin
      resume_reg <= 1'b1;
    end else if (fin || start_restore) begin
      resume_reg <= 1'b0;
    end
  end

  // ***************************************************************
  // register bank and pin outputs
  // ***************************************************************
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      cfg_addr <= '0;
      cfg_rd_en <= 1'b0;
      cfg_wr_en <= 1'b0;
      cfg_wr_data <= '0;
      cfg_update <= 1'b0;
      cfg_load_defaults <= 1'b0;
      status_pin <= 1'b0;
      i2c_nack <= 1'b0;
    end else begin
      cfg_addr <= rptr_reg;
      cfg_rd_en <= (state_reg == ST_DATA) && save_mode_reg && !fail;
      cfg_wr_en <= (state_reg == ST_DATA_WAIT) && !save_mode_reg;
      cfg_wr_data <= nvm_bus.rdata;
      // without a commit code restored bytes stay in the buffer bank
      cfg_update <= (is_commit && !save_mode_reg && !fail) ||
                    commit_wr;
      cfg_load_defaults <= !busy_reg && reset_event && !load_sel;
      status_pin <= status_sel && busy_reg;
      i2c_nack <= busy_reg;
    end
  end

  // ***************************************************************
  // host read path
  // ***************************************************************
  // two stage answer: the segment buffer needs one cycle to read
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      rd_valid_reg <= 1'b0;
      rd_blk_reg <= 1'b0;
      rd_addr_reg <= '0;
      reg_ack <= 1'b0;
      reg_rdata <= '0;
    end else begin
      rd_valid_reg <= reg_req;
      rd_blk_reg <= busy_reg;
      rd_addr_reg <= reg_addr;
      reg_ack <= rd_valid_reg;
      reg_rdata <= '0;
      if (rd_valid_reg) begin
        if (rd_addr_reg == ADDR_BUSY) begin
          reg_rdata[BIT_BUSY] <= busy_reg;
        end else if (rd_blk_reg) begin
          reg_rdata <= '0;
        end else if (rd_addr_reg == ADDR_ERROR) begin
          reg_rdata[BIT_ERROR] <= error_reg;
        end else if (rd_addr_reg == ADDR_WE_RELOAD) begin
          reg_rdata[BIT_WR_EN] <= wr_en_reg;
        end else if (rd_addr_reg == ADDR_SAVE_REQ) begin
          reg_rdata[BIT_SAVE_REQ] <= save_req_reg;
        end else if (is_seg(rd_addr_reg)) begin
          reg_rdata <= seg_bus.rdata;
        end
      end
    end
  end

endmodule : ncs_top

`default_nettype wire

// File: common/ncs_pkg.sv
// Function
// - store holds exactly 512 bytes
// - host has no direct path into store
// - busy blocks host access except busy read
// - i2c address refused with nack while busy
// - save copies registers and segment bytes
// - save request bit self clears after save
// - busy flag spans each transfer
// - status pin can mirror busy flag
// - error flag reports transfer failure
// - load pin high: restore on resets
// - load pin low: reload bit starts restore
// - load pin low at reset: defaults
// - default segment covers 0x000 to 0x231
// - group is count-minus-one, max 128
// - group address low byte then high
// - commit code during restore pulses update
// - no commit code leaves values buffered
// - end code terminates save or restore
// - pseudo end halts save, resumes later
// - commit bit self clears, updates all
`default_nettype none

package ncs_pkg;

  // ***************************************************************
  // sizes
  // ***************************************************************
  localparam int NVM_BYTES = 512;
  localparam int NVM_AW = 9;
  localparam int SEG_BYTES = 23;
  localparam int SEG_AW = 5;
  localparam int REG_AW = 16;

  // ***************************************************************
  // register map
  // ***************************************************************
  localparam logic [15:0] ADDR_COMMIT = 16'h0232;
  localparam logic [15:0] ADDR_SEG_BASE = 16'h0a00;
  localparam logic [15:0] ADDR_BUSY = 16'h0b00;
  localparam logic [15:0] ADDR_ERROR = 16'h0b01;
  localparam logic [15:0] ADDR_WE_RELOAD = 16'h0b02;
  localparam logic [15:0] ADDR_SAVE_REQ = 16'h0b03;
  localparam int BIT_BUSY = 0;
  localparam int BIT_ERROR = 0;
  localparam int BIT_WR_EN = 0;
  localparam int BIT_RELOAD = 1;
  localparam int BIT_SAVE_REQ = 0;
  localparam int BIT_COMMIT = 0;

  // ***************************************************************
  // segment codes
  // ***************************************************************
  localparam logic [7:0] OP_COMMIT = 8'h80;
  localparam logic [7:0] OP_PSEUDO_END = 8'hfe;
  localparam logic [7:0] OP_END = 8'hff;
  localparam logic [7:0] NVM_ERASED = 8'hff;
  localparam int OP_FLAG_BIT = 7;
  localparam logic [1:0] PH_COUNT = 2'h0;
  localparam logic [1:0] PH_ADDR_LO = 2'h1;
  localparam logic [1:0] PH_ADDR_HI = 2'h2;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_FETCH,
    ST_DECODE,
    ST_DATA,
    ST_DATA_WAIT
  } ncs_state_t;

  // power-up segment: four groups of 128 and one of 50, commit, end
  function automatic logic [7:0] ncs_seg_default(input int idx);
    case (idx)
      0, 3, 6, 9: return 8'h7f;
      12: return 8'h31;
      1, 2, 5, 7, 13: return 8'h00;
      4, 10: return 8'h80;
      8, 11: return 8'h01;
      14: return 8'h02;
      15: return OP_COMMIT;
      default: return OP_END;
    endcase
  endfunction : ncs_seg_default

endpackage : ncs_pkg

`default_nettype wire

// File: common/ncs_mem_if.sv
`default_nettype none

interface ncs_mem_if #(
  parameter int AW = 9,
  parameter int DW = 8
);
  logic [AW-1:0] addr;
  logic we;
  logic [DW-1:0] wdata;
  logic [DW-1:0] rdata;

  modport ctrl(output addr, output we, output wdata, input rdata);
  modport mem(input addr, input we, input wdata, output rdata);
endinterface : ncs_mem_if

`default_nettype wire

// File: verilog/ncs_nvm_store.sv
`default_nettype none

module ncs_nvm_store
  import ncs_pkg::*;
#(
  parameter int DEPTH = NVM_BYTES
) (
  // clock
  input wire logic sys_clk,
  // controller port
  ncs_mem_if.mem bus
);
  logic [7:0] mem [DEPTH];

  // erased cells read as all ones, so a blank store ends a restore at once
  initial begin
    for (int i = 0; i < DEPTH; i++) begin
      mem[i] = NVM_ERASED;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (bus.we) begin
      mem[bus.addr] <= bus.wdata;
    end
    bus.rdata <= mem[bus.addr];
  end
endmodule : ncs_nvm_store

`default_nettype wire

// File: verilog/ncs_seg_buffer.sv
`default_nettype none

module ncs_seg_buffer
  import ncs_pkg::*;
#(
  parameter int DEPTH = SEG_BYTES
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // shared host and controller port
  ncs_mem_if.mem bus
);
  logic [7:0] mem [DEPTH];

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= ncs_seg_default(i);
      end
    end else if (bus.we && (int'(bus.addr) < DEPTH)) begin
      mem[bus.addr] <= bus.wdata;
    end
  end

  // out of range reads look like an end code so a runaway walk stops
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      bus.rdata <= OP_END;
    end else if (int'(bus.addr) < DEPTH) begin
      bus.rdata <= mem[bus.addr];
    end else begin
      bus.rdata <= OP_END;
    end
  end
endmodule : ncs_seg_buffer

`default_nettype wire

// File: sim/ncs_top_chk.sv
`default_nettype none

module ncs_top_chk
  import ncs_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // pins and events
  input wire logic load_sel,
  input wire logic status_sel,
  input wire logic soft_reset_req,
  input wire logic status_pin,
  input wire logic i2c_nack,
  // host port
  input wire logic reg_req,
  input wire logic reg_wr,
  input wire logic [REG_AW-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_ack,
  input wire logic [7:0] reg_rdata,
  // bank port
  input wire logic cfg_rd_en,
  input wire logic cfg_wr_en,
  input wire logic cfg_update,
  input wire logic cfg_load_defaults
);
  // ********
  // checks
  // ********
  // i2c_nack lags busy by one cycle, so it stands in for busy at the request edge
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  AST_ACK_TWO: assert property (reg_req |-> ##2 reg_ack)
    else $error("access not answered after two cycles");
  AST_ACK_CAUSE: assert property (reg_ack |-> $past(reg_req, 2))
    else $error("answer without request");
  AST_BUSY_READ: assert property (reg_req && !reg_wr && reg_addr == ADDR_BUSY
    |-> ##2 reg_rdata == {7'h00, i2c_nack})
    else $error("busy read wrong");
  AST_BLOCKED: assert property ((reg_req && !reg_wr && reg_addr != ADDR_BUSY)
    ##1 i2c_nack |=> reg_rdata == 8'h00)
    else $error("read not blocked while busy");
  AST_STATUS: assert property (status_pin == ($past(status_sel) & i2c_nack))
    else $error("status pin does not mirror busy");
  AST_BANK_BUSY: assert property (cfg_rd_en || cfg_wr_en |-> i2c_nack)
    else $error("bank access outside a transfer");
  AST_UPD_PULSE: assert property (cfg_update |=> !cfg_update)
    else $error("update longer than one cycle");
  AST_COMMIT_UPD: assert property ((reg_req && reg_wr && reg_addr == ADDR_COMMIT
    && reg_wdata[0]) ##1 !i2c_nack |-> ##[0:3] cfg_update)
    else $error("commit write gave no update");
  AST_RST_DEF: assert property ($rose(reset_n) && !load_sel
    |-> ##[1:2] cfg_load_defaults)
    else $error("no defaults after reset");
  AST_RST_LOAD: assert property ($rose(reset_n) && load_sel |-> ##[1:3] i2c_nack)
    else $error("no restore after reset");
  AST_SOFT_DEF: assert property (soft_reset_req && !load_sel && !i2c_nack
    |-> ##[1:3] cfg_load_defaults)
    else $error("no defaults after soft reset");
  AST_SOFT_LOAD: assert property (soft_reset_req && load_sel && !i2c_nack
    |-> ##[1:3] i2c_nack)
    else $error("no restore after soft reset");
endmodule : ncs_top_chk

bind ncs_top ncs_top_chk u_chk (.sys_clk(sys_clk), .reset_n(reset_n),
  .load_sel(load_sel), .status_sel(status_sel), .soft_reset_req(soft_reset_req),
  .status_pin(status_pin), .i2c_nack(i2c_nack), .reg_req(reg_req), .reg_wr(reg_wr),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_ack(reg_ack), .reg_rdata(reg_rdata),
  .cfg_rd_en(cfg_rd_en), .cfg_wr_en(cfg_wr_en), .cfg_update(cfg_update),
  .cfg_load_defaults(cfg_load_defaults));

`default_nettype wire

// File: sim/ncs_bank_model.sv
`default_nettype none

module ncs_bank_model
  import ncs_pkg::*;
(
  // clock
  input wire logic sys_clk,
  // bank port
  input wire logic [REG_AW-1:0] cfg_addr,
  input wire logic cfg_rd_en,
  output logic [7:0] cfg_rd_data,
  input wire logic cfg_wr_en,
  input wire logic [7:0] cfg_wr_data,
  input wire logic cfg_update,
  input wire logic cfg_load_defaults
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] buf_bank [256];
  logic [7:0] act_bank [256];
  int n_def = 0;
  // data is good only while the read strobe stands; otherwise it is inverted junk
  assign cfg_rd_data = cfg_rd_en ? buf_bank[cfg_addr[7:0]] : ~buf_bank[cfg_addr[7:0]];
  always @(posedge sys_clk) begin
    if (cfg_wr_en) buf_bank[cfg_addr[7:0]] <= cfg_wr_data;
    if (cfg_update) act_bank <= buf_bank;
    if (cfg_load_defaults) n_def <= n_def + 1;
  end
endmodule : ncs_bank_model

`default_nettype wire

// File: sim/ncs_top_tb.sv
`default_nettype none

module ncs_top_tb
  import ncs_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic load_sel = 1'b0;
  logic status_sel = 1'b1;
  logic soft_reset_req = 1'b0;
  logic reg_req = 1'b0;
  logic reg_wr = 1'b0;
  logic [15:0] reg_addr = 16'h0000;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata, cfg_rd_data, cfg_wr_data, q, base;
  logic [15:0] cfg_addr;
  logic status_pin, i2c_nack, reg_ack, cfg_rd_en, cfg_wr_en, cfg_update, cfg_load_defaults;
  logic [7:0] exp_d [4];
  int seg_i [4] = '{0, 12, 15, 16};
  logic [7:0] seg_e [4] = '{8'h7f, 8'h31, 8'h80, 8'hff};
  int mismatches = 0;
  int n_tests = 0;
  int n;

  always #12.5 sys_clk = ~sys_clk;

  ncs_top uut (.sys_clk(sys_clk), .reset_n(reset_n), .load_sel(load_sel),
    .status_sel(status_sel), .soft_reset_req(soft_reset_req), .status_pin(status_pin),
    .i2c_nack(i2c_nack), .reg_req(reg_req), .reg_wr(reg_wr), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_ack(reg_ack), .reg_rdata(reg_rdata), .cfg_addr(cfg_addr),
    .cfg_rd_en(cfg_rd_en), .cfg_rd_data(cfg_rd_data), .cfg_wr_en(cfg_wr_en),
    .cfg_wr_data(cfg_wr_data), .cfg_update(cfg_update),
    .cfg_load_defaults(cfg_load_defaults));
  ncs_bank_model bank (.sys_clk(sys_clk), .cfg_addr(cfg_addr), .cfg_rd_en(cfg_rd_en),
    .cfg_rd_data(cfg_rd_data), .cfg_wr_en(cfg_wr_en), .cfg_wr_data(cfg_wr_data),
    .cfg_update(cfg_update), .cfg_load_defaults(cfg_load_defaults));

  // ********
  // tasks
  // ********
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // one-cycle request, answer two edges later
  task automatic xfer(input logic w, input logic [15:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_req <= 1'b1;
    reg_wr <= w;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_req <= 1'b0;
    // the answer is launched at this edge and stands until the next one
    @(posedge sys_clk);
    #1;
    q = reg_rdata;
    chk("ack", 8'h01, {7'h00, reg_ack});
  endtask : xfer

  task automatic wait_idle();
    int i;
    i = 0;
    xfer(1'b0, ADDR_BUSY, 8'h00);
    chk("busy_start", 8'h01, q);
    chk("nack", 8'h01, {7'h00, i2c_nack});
    chk("status", {7'h00, status_sel}, {7'h00, status_pin});
    do begin
      xfer(1'b0, ADDR_BUSY, 8'h00);
      i++;
    end while (q !== 8'h00 && i < 500);
    chk("busy_end", 8'h00, q);
    chk("nack_end", 8'h00, {7'h00, i2c_nack});
    repeat (400) @(posedge sys_clk);
  endtask : wait_idle

  task automatic save(input logic we, input logic long);
    xfer(1'b1, ADDR_WE_RELOAD, {7'h00, we});
    xfer(1'b1, ADDR_SAVE_REQ, 8'h01);
    xfer(1'b1, ADDR_COMMIT, 8'h01);
    if (long) begin
      xfer(1'b0, ADDR_SAVE_REQ, 8'h00);
      chk("blocked", 8'h00, q);
      wait_idle();
    end else
      repeat (50) @(posedge sys_clk);
    xfer(1'b0, ADDR_SAVE_REQ, 8'h00);
    chk("save_req", 8'h00, q);
    xfer(1'b1, ADDR_WE_RELOAD, 8'h00);
  endtask : save

  task automatic pulse_soft();
    @(posedge sys_clk);
    soft_reset_req <= 1'b1;
    @(posedge sys_clk);
    soft_reset_req <= 1'b0;
  endtask : pulse_soft

  // kinds: reload bit, soft reset, hardware reset
  task automatic restore(input int k);
    @(posedge sys_clk);
    load_sel <= (k != 0);
    if (k == 0)
      xfer(1'b1, ADDR_WE_RELOAD, 8'h02);
    else if (k == 1)
      pulse_soft();
    else begin
      reset_n <= 1'b0;
      repeat (20) @(posedge sys_clk);
      reset_n <= 1'b1;
    end
    wait_idle();
    load_sel <= 1'b0;
    xfer(1'b0, ADDR_ERROR, 8'h00);
    chk("load_error", 8'h00, q);
  endtask : restore

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : summarize

  // ********
  // tests
  // ********
  initial begin
    repeat (50000) @(posedge sys_clk);
    mismatches++;
    summarize();
  end

  initial begin
    void'($urandom(32'ha810));
    repeat (20) @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    chk("defaults", 8'h01, 8'(bank.n_def));
    pulse_soft();
    repeat (4) @(posedge sys_clk);
    chk("soft_defaults", 8'h02, 8'(bank.n_def));
    for (int i = 0; i < 4; i++) begin
      xfer(1'b0, ADDR_SEG_BASE + 16'(seg_i[i]), 8'h00);
      chk("seg_default", seg_e[i], q);
    end
    base = 8'($urandom);
    xfer(1'b1, ADDR_SEG_BASE + 16'h0016, base);
    xfer(1'b0, ADDR_SEG_BASE + 16'h0016, 8'h00);
    chk("seg_rw", base, q);
    xfer(1'b1, 16'h0c00, base);
    xfer(1'b0, 16'h0c00, 8'h00);
    chk("unmapped", 8'h00, q);
    xfer(1'b0, ADDR_COMMIT, 8'h00);
    chk("commit_read", 8'h00, q);
    $display("test map done");
    save(1'b0, 1'b0);
    xfer(1'b0, ADDR_ERROR, 8'h00);
    chk("error_no_we", 8'h01, q);
    xfer(1'b1, ADDR_SEG_BASE, 8'h90);
    save(1'b1, 1'b0);
    xfer(1'b0, ADDR_ERROR, 8'h00);
    chk("error_code", 8'h01, q);
    $display("test error done");
    for (int p = 0; p < 2; p++) begin
      n = $urandom_range(4, 1);
      base = 8'($urandom_range(200, 16));
      status_sel <= 1'($urandom);
      for (int i = 0; i < n; i++) begin
        exp_d[i] = 8'($urandom);
        bank.buf_bank[base + i] = exp_d[i];
        bank.act_bank[base + i] = exp_d[i];
      end
      xfer(1'b1, ADDR_SEG_BASE, 8'(n - 1));
      xfer(1'b1, ADDR_SEG_BASE + 16'h0001, base);
      xfer(1'b1, ADDR_SEG_BASE + 16'h0002, 8'h00);
      xfer(1'b1, ADDR_SEG_BASE + 16'h0003, p ? OP_END : OP_COMMIT);
      xfer(1'b1, ADDR_SEG_BASE + 16'h0004, OP_END);
      save(1'b1, 1'b1);
      xfer(1'b0, ADDR_ERROR, 8'h00);
      chk("save_error", 8'h00, q);
      for (int k = 0; k < 3; k++) begin
        for (int i = 0; i < n; i++) begin
          bank.buf_bank[base + i] = ~exp_d[i];
          bank.act_bank[base + i] = ~exp_d[i];
        end
        restore(k);
        for (int i = 0; i < n; i++) begin
          chk("buffer", exp_d[i], bank.buf_bank[base + i]);
          chk("active", p ? ~exp_d[i] : exp_d[i], bank.act_bank[base + i]);
        end
      end
      $display("test profile %0d done", p);
    end
    summarize();
  end
endmodule : ncs_top_tb

`default_nettype wire
